// File: hw/csf_pkg.sv
// shared constants of the controller system flag block
package csf_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_TICK_NS = 100000;
  localparam logic [3:0] SUB_PER_MS = 4'h9;
  localparam logic [3:0] DEC_WRAP = 4'h9;
  // square wave half periods in ms: 5ms, 50ms, 500ms, 30s for the 10ms, 100ms, 1s, 1min waves
  localparam logic [3:0][14:0] SQ_HALF_MS = {15'h7530, 15'h01F4, 15'h0032, 15'h0005};
  // year offset for four digit display
  localparam logic [11:0] YEAR_BASE = 12'h7D0;
  // matrix range
  localparam logic [8:0] MATRIX_LAST = 9'h0FF;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MATRIX = 8'h08;
  localparam logic [7:0] ADDR_HOSTCODE = 8'h0C;
  // control register fields
  localparam int C_YEAR = 0;
  localparam int C_MIDBASE = 1;
  localparam int C_UPRES = 2;
  localparam int C_PWM2 = 3;
  localparam int C_PWM4 = 4;
  localparam int C_PAUSE = 5;
  localparam int C_PWLVL = 6;
  localparam int C_MMODE = 7;
  localparam int C_PINC = 8;
  localparam int C_RUN = 9;
  // status register fields
  localparam int S_RUN = 0;
  localparam int S_RUNINV = 1;
  localparam int S_FSPOS = 2;
  localparam int S_FSNEG = 3;
  localparam int S_ERR = 4;
  localparam int S_WDT = 5;
  localparam int S_SQ = 6;
  localparam int S_MEND = 10;
  localparam int S_MSTART = 11;
  localparam int S_MFOUND = 12;
  localparam int S_MPERR = 13;
  localparam int S_HOSTERR = 14;
  localparam int S_OPSTATE = 15;
endpackage

// File: hw/csf_flags.sv
// system flag bits of the scan engine with an apb register slave
// Overview of operation
// - run indicator on while running, off at reset and after stop
// - inverted run contact is the complement of the run indicator
// - positive first-scan pulse high for exactly the first scan after run
// - negative first-scan pulse low for exactly the first scan after run
// - error flag sets on error, clears at reset and stop-to-run
// - watchdog flag sets on timeout, clears at reset and stop-to-run
// - free-running 10 ms square wave, equal halves, off at reset
// - free-running 100 ms square wave, 50 ms high and 50 ms low
// - free-running 1 s square wave, half a second each level
// - free-running 1 min square wave, thirty seconds each level
// - year shows two digits, or two digits plus 2000 when selected
// - mid timer group ticks at 100 ms, or 10 ms when selected
// - upper timer group ticks at 10 ms, or 1 ms when selected
// - pwm bases for second and fourth outputs: 100 us selected, else 1 ms
// - operating state bit on in run, set at run, cleared at stop
// - immediate pause halts second output at once, cleared at stop-to-run
// - seventh input width measured in on level or off level by mode
// - matrix compare looks for equal bits or for differing bits
// - end flag at last bit, start flag when compare starts at bit zero
// - matching bit stops the search and sets the found flag
// - pointer error flag while pointer lies beyond the valid range
// - pointer increment adds one to the matrix pointer
// - illegal host request sets the host error flag and stores its code
//
// Local design decisions: the placing of the registers and the APB register port.
module csf_flags #(
  parameter int PRE_CYCLES = csf_pkg::BASE_TICK_NS / csf_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // scan engine events
  input wire logic runSwitch,
  input wire logic scanEnd,
  input wire logic errorEvent,
  input wire logic watchdogTimeout,
  input wire logic hostReqError,
  input wire logic [15:0] hostErrCode,
  // run flags
  output logic runIndicatorContact,
  output logic runIndicatorInverted,
  output logic firstScanPulsePos,
  output logic firstScanPulseNeg,
  output logic operatingStateBit,
  // clock pulse bits
  output logic tick10msSquare,
  output logic tick100msSquare,
  output logic tick1sSquare,
  output logic tick1minSquare,
  // timer and pwm time bases, one-cycle pulses
  output logic midTimerTick,
  output logic upperTimerTick,
  output logic pwmSecondOutputTick,
  output logic pwmFourthOutputTick,
  // pulse output and input measurement
  output logic secondOutputHalt,
  input wire logic seventhInput,
  output logic pulseWidthGate,
  // calendar year
  input wire logic [6:0] yearDigits,
  output logic [11:0] yearValue,
  // matrix compare engine
  input wire logic matrixStart,
  input wire logic matrixDataBit,
  input wire logic matrixRefBit,
  output logic [8:0] matrixPointer,
  output logic matrixSearching
);
  import csf_pkg::*;

  localparam logic [13:0] PRE_WRAP = 14'(PRE_CYCLES - 1);

  typedef struct packed {
    logic [31:0] rdata;
    logic runReq;
    logic runSwPrev;
    logic running;
    logic firstScan;
    logic errFlag;
    logic wdtFlag;
    logic hostErr;
    logic [15:0] hostCode;
    logic [9:0] ctrl;
    logic [13:0] preCnt;
    logic [3:0] subCnt;
    logic [3:0] cnt10;
    logic [3:0] cnt100;
    logic t100us;
    logic t1ms;
    logic t10ms;
    logic t100ms;
    logic [3:0] sq;
    logic [3:0][14:0] sqCnt;
    logic searching;
    logic [8:0] ptr;
    logic mEnd;
    logic mStart;
    logic mFound;
  } csf_state_t;

  csf_state_t s_q;
  csf_state_t s_d;
  logic wrAcc;
  logic rdSetup;
  logic toRun;
  logic toStop;
  logic match;
  logic ptrErr;
  logic [31:0] ctrlView;
  logic [31:0] statView;

  // bus decode; every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrAcc = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign pslverr = psel && penable && (paddr != ADDR_CTRL) && (paddr != ADDR_STATUS)
                   && (paddr != ADDR_MATRIX) && (paddr != ADDR_HOSTCODE);

  // run state edges, taken from the registered request
  assign toRun = s_q.runReq && !s_q.running;
  assign toStop = !s_q.runReq && s_q.running;

  // equal search or differing search
  assign match = s_q.ctrl[C_MMODE] ? (matrixDataBit == matrixRefBit)
                                   : (matrixDataBit != matrixRefBit);
  assign ptrErr = s_q.ptr > MATRIX_LAST;

  // register views; increment bit is an action and reads zero
  always_comb begin
    ctrlView = '0;
    ctrlView[C_RUN:0] = s_q.ctrl;
    ctrlView[C_PINC] = 1'b0;
    statView = '0;
    statView[S_RUN] = s_q.running;
    statView[S_RUNINV] = !s_q.running;
    statView[S_FSPOS] = s_q.firstScan;
    statView[S_FSNEG] = !s_q.firstScan;
    statView[S_ERR] = s_q.errFlag;
    statView[S_WDT] = s_q.wdtFlag;
    statView[S_SQ +: 4] = s_q.sq;
    statView[S_MEND] = s_q.mEnd;
    statView[S_MSTART] = s_q.mStart;
    statView[S_MFOUND] = s_q.mFound;
    statView[S_MPERR] = ptrErr;
    statView[S_HOSTERR] = s_q.hostErr;
    statView[S_OPSTATE] = s_q.running;
  end

  // next state
  always_comb begin
    s_d = s_q;
    // read data latched in setup so it is stable for the access cycle
    if (rdSetup) begin
      unique case (paddr)
        ADDR_CTRL: s_d.rdata = ctrlView;
        ADDR_STATUS: s_d.rdata = statView;
        ADDR_MATRIX: s_d.rdata = {23'h000000, s_q.ptr};
        ADDR_HOSTCODE: s_d.rdata = {16'h0000, s_q.hostCode};
        default: s_d.rdata = '0;
      endcase
    end
    // run request follows switch edges, software writes override
    s_d.runSwPrev = runSwitch;
    if (runSwitch && !s_q.runSwPrev) begin
      s_d.runReq = 1'b1;
    end else if (!runSwitch && s_q.runSwPrev) begin
      s_d.runReq = 1'b0;
    end
    s_d.ctrl[C_PINC] = 1'b0;
    if (toRun) begin
      s_d.ctrl[C_PAUSE] = 1'b0;
    end
    if (wrAcc && paddr == ADDR_CTRL) begin
      s_d.ctrl = pwdata[C_RUN:0];
      s_d.runReq = pwdata[C_RUN];
    end
    s_d.running = s_q.runReq;
    // first scan lasts until the first end of scan after run
    if (toRun) begin
      s_d.firstScan = 1'b1;
    end else if (toStop || (scanEnd && s_q.running)) begin
      s_d.firstScan = 1'b0;
    end
    // sticky error flags; an event in the clearing cycle wins
    if (toRun) begin
      s_d.errFlag = 1'b0;
      s_d.wdtFlag = 1'b0;
    end
    if (errorEvent) begin
      s_d.errFlag = 1'b1;
    end
    if (watchdogTimeout) begin
      s_d.wdtFlag = 1'b1;
    end
    if (hostReqError) begin
      s_d.hostErr = 1'b1;
      s_d.hostCode = hostErrCode;
    end
    // time base, never reset by run or stop so the pulses stay periodic
    // a stop keeps the phase, so timers restarted in the next run see no glitch
    s_d.t100us = s_q.preCnt == PRE_WRAP;
    s_d.preCnt = s_d.t100us ? '0 : s_q.preCnt + 14'h0001;
    s_d.t1ms = s_q.t100us && s_q.subCnt == SUB_PER_MS;
    if (s_q.t100us) begin
      s_d.subCnt = (s_q.subCnt == SUB_PER_MS) ? '0 : s_q.subCnt + 4'h1;
    end
    s_d.t10ms = s_q.t1ms && s_q.cnt10 == DEC_WRAP;
    if (s_q.t1ms) begin
      s_d.cnt10 = (s_q.cnt10 == DEC_WRAP) ? '0 : s_q.cnt10 + 4'h1;
    end
    s_d.t100ms = s_q.t10ms && s_q.cnt100 == DEC_WRAP;
    if (s_q.t10ms) begin
      s_d.cnt100 = (s_q.cnt100 == DEC_WRAP) ? '0 : s_q.cnt100 + 4'h1;
    end
    // square waves toggle every half period counted in ms
    for (int i = 0; i < 4; i++) begin
      if (s_q.t1ms) begin
        if (s_q.sqCnt[i] == SQ_HALF_MS[i] - 15'h0001) begin
          s_d.sqCnt[i] = '0;
          s_d.sq[i] = !s_q.sq[i];
        end else begin
          s_d.sqCnt[i] = s_q.sqCnt[i] + 15'h0001;
        end
      end
    end
    // matrix search engine, one bit per clock
    if (toRun) begin
      s_d.mEnd = 1'b0;
      s_d.mStart = 1'b0;
      s_d.mFound = 1'b0;
      s_d.searching = 1'b0;
    end
    if (matrixStart) begin
      s_d.ptr = '0;
      s_d.mStart = 1'b1;
      s_d.mEnd = 1'b0;
      s_d.mFound = 1'b0;
      s_d.searching = 1'b1;
    end else if (s_q.searching) begin
      if (match) begin
        s_d.mFound = 1'b1;
        s_d.searching = 1'b0;
      end else if (s_q.ptr >= MATRIX_LAST) begin
        s_d.mEnd = 1'b1;
        s_d.searching = 1'b0;
      end else begin
        s_d.ptr = s_q.ptr + 9'h001;
      end
    end else if (wrAcc && paddr == ADDR_CTRL && pwdata[C_PINC]) begin
      s_d.ptr = s_q.ptr + 9'h001;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign prdata = s_q.rdata;
  assign runIndicatorContact = s_q.running;
  assign runIndicatorInverted = !s_q.running;
  assign firstScanPulsePos = s_q.firstScan;
  assign firstScanPulseNeg = !s_q.firstScan;
  assign operatingStateBit = s_q.running;
  assign tick10msSquare = s_q.sq[0];
  assign tick100msSquare = s_q.sq[1];
  assign tick1sSquare = s_q.sq[2];
  assign tick1minSquare = s_q.sq[3];
  assign midTimerTick = s_q.ctrl[C_MIDBASE] ? s_q.t10ms : s_q.t100ms;
  assign upperTimerTick = s_q.ctrl[C_UPRES] ? s_q.t1ms : s_q.t10ms;
  assign pwmSecondOutputTick = s_q.ctrl[C_PWM2] ? s_q.t100us : s_q.t1ms;
  assign pwmFourthOutputTick = s_q.ctrl[C_PWM4] ? s_q.t100us : s_q.t1ms;
  assign secondOutputHalt = s_q.ctrl[C_PAUSE];
  assign pulseWidthGate = seventhInput == s_q.ctrl[C_PWLVL];
  // digits are binary 0..99, so the sum never exceeds twelve bits
  assign yearValue = s_q.ctrl[C_YEAR] ? YEAR_BASE + {5'h00, yearDigits}
                                      : {5'h00, yearDigits};
  assign matrixPointer = s_q.ptr;
  assign matrixSearching = s_q.searching;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  run_complement_a: assert property (
    runIndicatorContact != runIndicatorInverted && runIndicatorContact == $past(s_q.runReq))
    else $error("run contacts not complementary or late");
  first_pos_a: assert property (toRun |=> firstScanPulsePos && operatingStateBit)
    else $error("first scan pulse missing after run");
  first_neg_a: assert property (firstScanPulsePos && scanEnd |=> firstScanPulseNeg)
    else $error("negative first scan pulse too long");
  err_set_a: assert property (errorEvent |=> s_q.errFlag)
    else $error("error flag not set");
  err_clr_a: assert property (toRun && !errorEvent |=> !s_q.errFlag)
    else $error("error flag not cleared at run");
  wdt_set_a: assert property (watchdogTimeout |=> s_q.wdtFlag)
    else $error("watchdog flag not set");
  square_step_a: assert property ($changed(tick10msSquare) |-> $past(s_q.t1ms))
    else $error("square wave moved off the ms tick");
  pause_clr_a: assert property (toRun && !wrAcc |=> !secondOutputHalt)
    else $error("pause not cleared at run");
  found_stop_a: assert property (
    s_q.searching && match && !matrixStart |=> s_q.mFound && !s_q.searching)
    else $error("search did not stop on match");
  end_flag_a: assert property (
    s_q.searching && !match && !matrixStart && s_q.ptr == MATRIX_LAST
    |=> s_q.mEnd && !s_q.searching)
    else $error("end flag missing at last bit");
  ptr_inc_a: assert property (
    wrAcc && paddr == ADDR_CTRL && pwdata[C_PINC] && !s_q.searching && !matrixStart
    |=> matrixPointer == $past(matrixPointer) + 9'h001)
    else $error("pointer not incremented");
  host_err_a: assert property (
    hostReqError |=> s_q.hostErr && s_q.hostCode == $past(hostErrCode))
    else $error("host error not captured");

  // run state and first scan
  run_stop_a: assert property (toStop |=> !runIndicatorContact && !firstScanPulsePos)
    else $error("run flags not cleared at stop");
  run_low_a: assert property (toRun |=> !runIndicatorInverted && !firstScanPulseNeg)
    else $error("inverted flags not low at run");
  first_hold_a: assert property (
    firstScanPulsePos && !scanEnd && !toStop |=> firstScanPulsePos)
    else $error("first scan pulse ended early");

  // sticky flags and pause
  wdt_clr_a: assert property (toRun && !watchdogTimeout |=> !s_q.wdtFlag)
    else $error("watchdog flag not cleared at run");
  host_hold_a: assert property (
    s_q.hostErr && !hostReqError |=> s_q.hostErr && $stable(s_q.hostCode))
    else $error("host error code lost");
  halt_hold_a: assert property (
    secondOutputHalt && !toRun && !wrAcc |=> secondOutputHalt)
    else $error("pause dropped without a write or run entry");

  // time bases; a changed select may legally give two pulses in a row
  square_run_a: assert property (
    (toRun || toStop) && !s_q.t1ms |=> $stable(s_q.sq))
    else $error("square waves disturbed by run state");
  mid_pulse_a: assert property (midTimerTick && !wrAcc |=> !midTimerTick)
    else $error("mid timer tick longer than one cycle");
  upper_pulse_a: assert property (upperTimerTick && !wrAcc |=> !upperTimerTick)
    else $error("upper timer tick longer than one cycle");

  // matrix engine
  start_flag_a: assert property (
    matrixStart |=> s_q.mStart && s_q.searching && matrixPointer == 9'h000)
    else $error("search did not start at bit zero");
  search_step_a: assert property (
    s_q.searching && !match && !matrixStart && !toRun && s_q.ptr < MATRIX_LAST
    |=> s_q.searching && matrixPointer == $past(matrixPointer) + 9'h001)
    else $error("search did not step to the next bit");

  // main scenarios reached
  run_entry_c: cover property (toRun ##[1:60] scanEnd);
  match_found_c: cover property (matrixStart ##[1:50] s_q.mFound);
  host_error_c: cover property (hostReqError);
  stop_entry_c: cover property (toStop);
  ptr_error_c: cover property (ptrErr);
endmodule

// File: tb/csf_scan_model.sv
// user program model: ends one scan every SCAN cycles while the engine runs
module csf_scan_model #(
  parameter int SCAN = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic sysRst,
  // engine state
  input wire logic running,
  output logic scanEnd
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // no scans while stopped, so the first scan always starts at run entry
  always @(posedge clk) begin
    if (sysRst || !running) begin
      cnt <= 0;
      scanEnd <= 1'b0;
    end else begin
      cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
      scanEnd <= (cnt == SCAN - 1);
    end
  end
endmodule

// File: tb/tb_controller_system_status_flags.sv
// self-checking bench of the system flag block over its apb port
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_controller_system_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import csf_pkg::*;
  logic clk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic pready, pslverr, slvErr, runSwitch = 1'b0, scanEnd, errorEvent = 1'b0;
  logic watchdogTimeout = 1'b0, hostReqError = 1'b0, seventhInput = 1'b0;
  logic [15:0] hostErrCode = 16'h0;
  logic runC, runI, fsP, fsN, opSt, sq10, sq100, sq1s, sq1m, midT, upT, pw2, pw4, halt, pwGate;
  logic [6:0] yearDigits = 7'h17;
  logic [11:0] yearValue;
  logic matrixStart = 1'b0, matrixDataBit = 1'b0, matrixRefBit = 1'b0, matrixSearching;
  logic [8:0] matrixPointer;
  int miscompares = 0, samplesChecked = 0;
  wire [5:0] ev = {sq100, sq10, pw4, pw2, upT, midT};

  always #5 clk = ~clk;

  // 100 us base tick every 10 cycles keeps the long counts short
  csf_flags #(.PRE_CYCLES(10)) uut (.clk(clk), .sys_rst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .runSwitch(runSwitch), .scanEnd(scanEnd),
    .errorEvent(errorEvent), .watchdogTimeout(watchdogTimeout), .hostReqError(hostReqError),
    .hostErrCode(hostErrCode), .runIndicatorContact(runC), .runIndicatorInverted(runI),
    .firstScanPulsePos(fsP), .firstScanPulseNeg(fsN), .operatingStateBit(opSt),
    .tick10msSquare(sq10), .tick100msSquare(sq100), .tick1sSquare(sq1s),
    .tick1minSquare(sq1m), .midTimerTick(midT), .upperTimerTick(upT),
    .pwmSecondOutputTick(pw2), .pwmFourthOutputTick(pw4), .secondOutputHalt(halt),
    .seventhInput(seventhInput), .pulseWidthGate(pwGate), .yearDigits(yearDigits),
    .yearValue(yearValue), .matrixStart(matrixStart), .matrixDataBit(matrixDataBit),
    .matrixRefBit(matrixRefBit), .matrixPointer(matrixPointer),
    .matrixSearching(matrixSearching));

  csf_scan_model #(.SCAN(40)) scanModel (.clk(clk), .sysRst(sysRst), .running(runC),
    .scanEnd(scanEnd));

  task automatic final_report();
    $display("compares %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never reassigns psel in this step
    @(posedge clk);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdData & m, e)
  endtask

  // period and high time between two rises of one strobe or square
  task automatic tick(input logic [31:0] c, input int i, input int per, input int hi);
    int p, h;
    apb(1'b1, ADDR_CTRL, c);
    p = 0;
    h = 0;
    @(negedge clk);
    while (ev[i] !== 1'b0 && p < 30000) begin
      @(negedge clk);
      p++;
    end
    while (ev[i] !== 1'b1 && p < 30000) begin
      @(negedge clk);
      p++;
    end
    p = 0;
    while (ev[i] === 1'b1) begin
      h++;
      @(negedge clk);
      p++;
    end
    while (ev[i] === 1'b0 && p < 30000) begin
      @(negedge clk);
      p++;
    end
    `CHK(p, per)
    `CHK(h, hi)
  endtask

  // search from bit zero and wait for the engine to stop
  task automatic msearch(input logic [8:0] ptr, input logic [31:0] flag);
    int n;
    matrixStart <= 1'b1;
    @(posedge clk);
    matrixStart <= 1'b0;
    n = 0;
    repeat (2) @(negedge clk);
    while (matrixSearching !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK(matrixPointer, ptr)
    @(posedge clk);
    rdChk(ADDR_MATRIX, 32'h1FF, {23'h0, ptr});
    rdChk(ADDR_STATUS, flag, flag);
  endtask

  // tests need about 50000 cycles, mostly the two 100 ms measurements
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    // reset state, read-only and unmapped places
    rdChk(ADDR_STATUS, 32'hFFFFFC3F, 32'h0000000A);
    `CHK({runC, runI, fsP, fsN, opSt, sq1s, sq1m}, 7'h28)
    apb(1'b1, ADDR_STATUS, 32'hFFFF);
    rdChk(ADDR_STATUS, 32'hFC3F, 32'h000A);
    rdChk(8'h10, 32'hFFFFFFFF, 32'h0);
    `CHK(slvErr, 1'b1)
    $display("test reset done");
    // run entry, first scan, events, stop, run again by switch
    apb(1'b1, ADDR_CTRL, 32'h200);
    rdChk(ADDR_STATUS, 32'hFC3F, 32'h8005);
    `CHK({runC, runI, fsP, fsN, opSt}, 5'h15)
    repeat (50) @(posedge clk);
    rdChk(ADDR_STATUS, 32'hFC3F, 32'h8009);
    `CHK({runC, runI, fsP, fsN, opSt}, 5'h13)
    errorEvent <= 1'b1;
    watchdogTimeout <= 1'b1;
    hostReqError <= 1'b1;
    hostErrCode <= 16'hBEEF;
    @(posedge clk);
    errorEvent <= 1'b0;
    watchdogTimeout <= 1'b0;
    hostReqError <= 1'b0;
    @(posedge clk);
    rdChk(ADDR_STATUS, 32'hFC3F, 32'hC039);
    rdChk(ADDR_HOSTCODE, 32'hFFFFFFFF, 32'hBEEF);
    apb(1'b1, ADDR_CTRL, 32'h020);
    rdChk(ADDR_STATUS, 32'hFC3F, 32'h403A);
    `CHK({runC, runI, fsP, fsN, opSt}, 5'h0A)
    `CHK(halt, 1'b1)
    runSwitch <= 1'b1;
    repeat (4) @(posedge clk);
    rdChk(ADDR_STATUS, 32'hFC3F, 32'hC005);
    `CHK(halt, 1'b0)
    $display("test run done");
    // year display and pulse width level
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_CTRL, i ? 32'h41 : 32'h0);
      seventhInput <= 1'b1;
      @(posedge clk);
      `CHK(yearValue, i ? 12'h7E7 : 12'h017)
      `CHK(pwGate, i[0])
      seventhInput <= 1'b0;
      @(posedge clk);
      `CHK(pwGate, !i[0])
    end
    $display("test year done");
    // both compare modes, end at last bit, found at first, pointer step
    matrixRefBit <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h080);
    msearch(9'h0FF, 32'h0C00);
    apb(1'b1, ADDR_CTRL, 32'h180);
    rdChk(ADDR_MATRIX, 32'h1FF, 32'h100);
    rdChk(ADDR_STATUS, 32'h2000, 32'h2000);
    matrixDataBit <= 1'b1;
    msearch(9'h000, 32'h1800);
    apb(1'b1, ADDR_CTRL, 32'h000);
    msearch(9'h0FF, 32'h0C00);
    $display("test matrix done");
    // time bases, defaults then alternates; 1 ms is 100 cycles here
    tick(32'h00, 0, 10000, 1);
    tick(32'h00, 1, 1000, 1);
    tick(32'h00, 2, 100, 1);
    tick(32'h00, 3, 100, 1);
    tick(32'h1E, 0, 1000, 1);
    tick(32'h1E, 1, 100, 1);
    tick(32'h1E, 2, 10, 1);
    tick(32'h1E, 3, 10, 1);
    tick(32'h200, 4, 1000, 500);
    tick(32'h000, 5, 10000, 5000);
    $display("test ticks done");
    final_report();
  end
endmodule
